// file: hdl/eiu_top.sv
// Extended interrupt unit: flags, enables, priorities, power-fail, baud doubler
`timescale 1ns/1ps
`include "eiu_consts.svh"
module eiu_top (
    input  wire logic          core_clk,
    input  wire logic          rst,
    input  wire logic          ext_irq5_pin_low,
    input  wire logic          ext_irq4_pin_high,
    input  wire logic          ext_irq3_pin_low,
    input  wire logic          ext_irq2_pin_high,
    input  wire logic          powerfail_pin,
    input  wire logic [7:0]    sfr_addr,
    input  wire logic [7:0]    sfr_wdata,
    input  wire logic          sfr_wr,
    input  wire logic          sfr_rd,
    output logic      [7:0]    sfr_rdata,
    output logic               sfr_hit,
    output logic               irq_req,
    output logic               irq_high_prio,
    output eiu_pkg::eiu_src_t  irq_source,
    output logic               uart1_baud_doubler
);
    import eiu_pkg::*;

    // Stored software-visible state
    logic [3:0] irq_flags;        // Flags for sources 5..2 in bits 3..0
    logic       powerfail_flag;   // Power-fail event flag
    logic       powerfail_irq_enable;
    logic       baud_doubler_bit;
    logic [3:0] irq_enables;      // Bit 3 source 5 .. bit 0 source 2
    logic [3:0] irq_priorities;   // Same layout as enables

    // Edge detector hookup: bit 4 power-fail, bits 3..0 sources 5..2
    eiu_edge_if #(.WIDTH(5)) edge_bus ();
    wire [4:0] edge_pulse;

    // Active-low pins inverted so all edges look like rises
    assign edge_bus.pin_level = {powerfail_pin,
                                 ~ext_irq5_pin_low,    // RULE1
                                 ext_irq4_pin_high,    // RULE2
                                 ~ext_irq3_pin_low,    // RULE3
                                 ext_irq2_pin_high};   // RULE4
    assign edge_pulse = edge_bus.edge_pulse;

    eiu_edge_detect #(.WIDTH(5)) u_edge (
        .core_clk (core_clk),
        .rst      (rst),
        .edges    (edge_bus)
    );

    // Address decode for writes
    wire wr_flags = sfr_wr && (sfr_addr == `EIU_ADDR_FLAGS);
    wire wr_ctl   = sfr_wr && (sfr_addr == `EIU_ADDR_CONTROL);
    wire wr_en    = sfr_wr && (sfr_addr == `EIU_ADDR_ENABLES);
    wire wr_prio  = sfr_wr && (sfr_addr == `EIU_ADDR_PRIORITIES);

    // Flag next values: software write, then hardware set wins last
    wire [3:0] sw_flags  = wr_flags ? sfr_wdata[7:4] : irq_flags;  // RULE6
    wire [3:0] next_irq_flags = sw_flags | edge_pulse[3:0];         // RULE5 RULE19
    wire       sw_pf     = wr_ctl ? sfr_wdata[`EIU_CTL_PF_FLAG] : powerfail_flag; // RULE12
    wire       next_powerfail_flag = sw_pf | edge_pulse[4];         // RULE10 RULE19

    // Flag and control registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_flags            <= 4'h0;
            powerfail_flag       <= 1'b0;
            powerfail_irq_enable <= 1'b0;
            baud_doubler_bit     <= 1'b0;
        end else begin
            irq_flags      <= next_irq_flags;
            powerfail_flag <= next_powerfail_flag;
            if (wr_ctl) begin
                powerfail_irq_enable <= sfr_wdata[`EIU_CTL_PF_ENABLE];
                baud_doubler_bit     <= sfr_wdata[`EIU_CTL_DOUBLER];
            end
        end
    end

    // Enable and priority registers; bit 4 not stored
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_enables    <= 4'h0;
            irq_priorities <= 4'h0;
        end else begin
            if (wr_en) begin
                irq_enables <= sfr_wdata[3:0];      // RULE16
            end
            if (wr_prio) begin
                irq_priorities <= sfr_wdata[3:0];   // RULE16
            end
        end
    end

    // Read images with reserved bits fixed
    wire [7:0] img_flags_r = {irq_flags, 4'h8};                       // RULE14 RULE15
    wire [7:0] img_ctl = {baud_doubler_bit, 1'b1, powerfail_irq_enable,
                          powerfail_flag, 4'h0};                      // RULE14 RULE15
    wire [7:0] img_en   = {3'h7, 1'b0, irq_enables};                  // RULE14 RULE16
    wire [7:0] img_prio = {3'h7, 1'b0, irq_priorities};               // RULE14 RULE16

    // Read mux; unmapped addresses return zero and no hit
    wire       rd_hit = (sfr_addr == `EIU_ADDR_FLAGS) || (sfr_addr == `EIU_ADDR_CONTROL) ||
                        (sfr_addr == `EIU_ADDR_ENABLES) || (sfr_addr == `EIU_ADDR_PRIORITIES);
    wire [7:0] rd_mux = (sfr_addr == `EIU_ADDR_FLAGS)   ? img_flags_r :
                        (sfr_addr == `EIU_ADDR_CONTROL) ? img_ctl :
                        (sfr_addr == `EIU_ADDR_ENABLES) ? img_en :
                        (sfr_addr == `EIU_ADDR_PRIORITIES) ? img_prio : 8'h00;

    // Gated pending sources, power-fail in pend_pf, bits 3..0 sources 5..2
    wire [3:0] pend_ext = irq_flags & irq_enables;                    // RULE7
    wire       pend_pf  = powerfail_flag & powerfail_irq_enable;      // RULE9 RULE11
    wire [3:0] pend_hi  = pend_ext & irq_priorities;                  // RULE8
    wire [3:0] pend_lo  = pend_ext & ~irq_priorities;                 // RULE8

    // Fixed order within a level: power-fail, then 2, 3, 4, 5
    function automatic eiu_src_t pick_src(input logic [3:0] pend, input logic pf);
        eiu_src_t s;
        s = EIU_SRC_NONE;
        if (pf)           s = EIU_SRC_PF;
        else if (pend[0]) s = EIU_SRC_IRQ2;
        else if (pend[1]) s = EIU_SRC_IRQ3;
        else if (pend[2]) s = EIU_SRC_IRQ4;
        else if (pend[3]) s = EIU_SRC_IRQ5;
        return s;
    endfunction

    // Power-fail treated as high priority; high level served first
    wire       any_hi = pend_pf | (|pend_hi);
    wire       any_lo = |pend_lo;
    wire eiu_src_t next_irq_source = any_hi ? pick_src(pend_hi, pend_pf) :  // RULE18
                                     pick_src(pend_lo, 1'b0);

    // Registered outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sfr_rdata          <= 8'h00;
            sfr_hit            <= 1'b0;
            irq_req            <= 1'b0;
            irq_high_prio      <= 1'b0;
            irq_source         <= EIU_SRC_NONE;
            uart1_baud_doubler <= 1'b0;
        end else begin
            sfr_rdata          <= sfr_rd ? rd_mux : 8'h00;
            sfr_hit            <= sfr_rd & rd_hit;
            irq_req            <= any_hi | any_lo;             // RULE6 RULE12
            irq_high_prio      <= any_hi;                      // RULE18
            irq_source         <= next_irq_source;
            uart1_baud_doubler <= baud_doubler_bit;            // RULE13
        end
    end
endmodule // eiu_top

// file: hdl/eiu_consts.svh
// Register offsets, field positions, reset values for the extended irq unit
// Summary of operation
// RULE1 - Falling edge on irq5 pin sets flag
// RULE2 - Rising edge on irq4 pin sets flag
// RULE3 - Falling edge on irq3 pin sets flag
// RULE4 - Rising edge on irq2 pin sets flag
// RULE5 - Flags stay set until software clears
// RULE6 - Software writing one raises enabled interrupt
// RULE7 - Enable bits three to zero gate sources
// RULE8 - Priority bit one means high priority
// RULE9 - Power-fail requests need power-fail enable bit
// RULE10 - Power-fail pin event sets power-fail flag
// RULE11 - Uncleared power-fail flag requests again
// RULE12 - Software writing power-fail flag raises interrupt
// RULE13 - Control bit seven doubles second port baud
// RULE14 - Listed reserved bits read back as one
// RULE15 - Listed reserved bits read back as zero
// RULE16 - Enable and priority bit four read zero
// RULE17 - Pins synchronised, one flag set per edge
// RULE18 - High priority presented before low priority
// RULE19 - Hardware set beats simultaneous software clear
`ifndef EIU_CONSTS_SVH
`define EIU_CONSTS_SVH

`define EIU_ADDR_FLAGS      8'h91
`define EIU_ADDR_CONTROL    8'hd8
`define EIU_ADDR_ENABLES    8'he8
`define EIU_ADDR_PRIORITIES 8'hf8

`define EIU_RST_FLAGS       8'h08
`define EIU_RST_CONTROL     8'h40
`define EIU_RST_ENABLES     8'he0
`define EIU_RST_PRIORITIES  8'he0

`define EIU_FLAGS_LSB       4
`define EIU_CTL_DOUBLER     7
`define EIU_CTL_PF_ENABLE   5
`define EIU_CTL_PF_FLAG     4

`define EIU_FLAGS_RSVD_ONES 8'h08
`define EIU_CTL_RSVD_ONES   8'h40
`define EIU_EN_RSVD_ONES    8'he0

`define EIU_SYNC_STAGES     2

`endif

// file: hdl/eiu_pkg.sv
// Types shared by the extended irq unit files
package eiu_pkg;
    // Source identifiers as presented to the core
    typedef enum logic [2:0] {
        EIU_SRC_NONE = 3'h0,
        EIU_SRC_PF   = 3'h1,
        EIU_SRC_IRQ2 = 3'h2,
        EIU_SRC_IRQ3 = 3'h3,
        EIU_SRC_IRQ4 = 3'h4,
        EIU_SRC_IRQ5 = 3'h5
    } eiu_src_t;

    // Arbiter state: idle or presenting a request
    typedef enum logic [0:0] {
        EIU_ARB_IDLE = 1'b0,
        EIU_ARB_REQ  = 1'b1
    } eiu_arb_t;
endpackage

// file: hdl/eiu_edge_if.sv
// Interface carrying pin levels in and edge pulses out of the edge detector
`timescale 1ns/1ps
interface eiu_edge_if #(parameter int WIDTH = 5);
    logic [WIDTH-1:0] pin_level;   // Raw pin levels, asserted-polarity
    logic [WIDTH-1:0] edge_pulse;  // One-cycle pulse per asserting edge

    modport detector (input pin_level, output edge_pulse);
    modport user     (output pin_level, input edge_pulse);
endinterface // eiu_edge_if

// file: hdl/eiu_edge_detect.sv
// Pin synchroniser and asserting-edge detector for the extended irq unit
`timescale 1ns/1ps
`include "eiu_consts.svh"
module eiu_edge_detect #(
    parameter int WIDTH = 5
) (
    input  wire logic core_clk,
    input  wire logic rst,
    eiu_edge_if.detector edges
);
    import eiu_pkg::*;

    logic [WIDTH-1:0] sync_first;   // First stage, read only by second
    logic [WIDTH-1:0] sync_second;  // Second stage, stable level
    logic [WIDTH-1:0] level_prev;   // Previous stable level

    // Two-flop synchroniser then one history flop
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync_first  <= '0;
            sync_second <= '0;
            level_prev  <= '0;
        end else begin
            sync_first  <= edges.pin_level;   // RULE17
            sync_second <= sync_first;
            level_prev  <= sync_second;
        end
    end

    // Pulse once per rise of the asserted level
    assign edges.edge_pulse = sync_second & ~level_prev;  // RULE17
endmodule // eiu_edge_detect

// file: verification/eiu_properties.sv
// Port-level checks of the extended irq unit
`timescale 1ns/1ps
module eiu_props (
    input logic core_clk, rst, sfr_wr, sfr_rd, sfr_hit, irq_req, irq_high_prio,
    input logic ext_irq5_pin_low, ext_irq4_pin_high, ext_irq3_pin_low, ext_irq2_pin_high,
    input logic powerfail_pin, uart1_baud_doubler,
    input logic [7:0] sfr_addr, sfr_wdata, sfr_rdata,
    input eiu_pkg::eiu_src_t irq_source
);
    import eiu_pkg::*;
    logic [5:0] en, pr, en_q, pr_q;  // Shadows indexed by source code
    wire is_ep = sfr_addr[3:0] == 4'h8 && sfr_addr[7:5] == 3'h7;  // Enable or priority
    wire is_map = sfr_addr == 8'h91 || sfr_addr == 8'hd8 || is_ep;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Delayed copy matches the two-cycle request latency
    always_ff @(posedge core_clk) begin
        if (rst) begin
            en <= 6'h0; pr <= 6'h02; en_q <= 6'h0; pr_q <= 6'h02;
        end else begin
            if (sfr_wr && sfr_addr == 8'he8) en[5:2] <= sfr_wdata[3:0];
            if (sfr_wr && sfr_addr == 8'hd8) en[1] <= sfr_wdata[5];
            if (sfr_wr && sfr_addr == 8'hf8) pr[5:2] <= sfr_wdata[3:0];
            en_q <= en;
            pr_q <= pr;
        end
    end
    property p_unmap; $past(sfr_rd && !is_map) |-> sfr_rdata == 8'h0 && !sfr_hit; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read answered");
    property p_flg; $past(sfr_rd && sfr_addr == 8'h91) |-> sfr_rdata[3:0] == 4'h8 && sfr_hit;
    endproperty
    a_flg: assert property (p_flg) else $error("flag reserved bits wrong");
    property p_ctl; $past(sfr_rd && sfr_addr == 8'hd8) |-> sfr_rdata[6] && sfr_rdata[3:0] == 0;
    endproperty
    a_ctl: assert property (p_ctl) else $error("control reserved bits wrong");
    property p_enp; $past(sfr_rd && is_ep) |-> sfr_rdata[7:4] == 4'he; endproperty
    a_enp: assert property (p_enp) else $error("enable or priority high nibble wrong");
    property p_dbl; sfr_wr && sfr_addr == 8'hd8 && sfr_wdata[7] |-> ##[1:2] uart1_baud_doubler;
    endproperty
    a_dbl: assert property (p_dbl) else $error("baud doubler not set");
    property p_en; irq_req |-> en_q[irq_source]; endproperty
    a_en: assert property (p_en) else $error("request from disabled source");
    property p_pri; irq_req |-> irq_high_prio == pr_q[irq_source]; endproperty
    a_pri: assert property (p_pri) else $error("priority level wrong");
    property p_e5; $fell(ext_irq5_pin_low) && en[5] |-> ##[1:5] irq_req; endproperty
    a_e5: assert property (p_e5) else $error("falling edge not requested");
    property p_pf; $rose(powerfail_pin) && en[1] |-> ##[1:5] irq_req && irq_high_prio;
    endproperty
    a_pf: assert property (p_pf) else $error("power-fail not requested");
    c_hi: cover property (irq_req && irq_high_prio);
    c_pf: cover property (irq_source == EIU_SRC_PF);
    c_dbl: cover property (uart1_baud_doubler);
endmodule // eiu_props

// file: verification/eiu_src_model.sv
// External interrupt sources and power-fail monitor driving the unit's pins
`timescale 1ns/1ps
module eiu_src_model (
    input  logic       core_clk,
    input  logic [4:0] fire,
    output logic       ext_irq5_pin_low, ext_irq4_pin_high, ext_irq3_pin_low,
    output logic       ext_irq2_pin_high, powerfail_pin
);
    logic [4:0] act = 5'h0;  // Asserted level per source, pf in bit 0
    // Pins move only just after an edge, like a real synchronous source
    always @(posedge core_clk) begin
        act <= fire;
    end
    // Low-active pins idle high
    assign {ext_irq5_pin_low, ext_irq4_pin_high, ext_irq3_pin_low, ext_irq2_pin_high,
            powerfail_pin} = {~act[4], act[3], ~act[2], act[1], act[0]};
endmodule // eiu_src_model

// file: verification/testbench.sv
// Self-checking bench for the extended irq unit
`timescale 1ns/1ps
module testbench;
    import eiu_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h0, sfr_wdata = 8'h0, sfr_rdata, e, p, f, c;
    logic [4:0] fire = 5'h0;
    logic p5, p4, p3, p2, pf, sfr_hit, irq_req, irq_high_prio, uart1_baud_doubler;
    logic [3:0] x;
    eiu_src_t irq_source;
    int miscompares = 0, n_checks = 0, cycles = 0;
    logic [31:0] seed = 32'd21282;
    always #5 core_clk = ~core_clk;
    eiu_src_model model (.core_clk(core_clk), .fire(fire), .ext_irq5_pin_low(p5),
        .ext_irq4_pin_high(p4), .ext_irq3_pin_low(p3), .ext_irq2_pin_high(p2),
        .powerfail_pin(pf));
    eiu_top dut (.core_clk(core_clk), .rst(rst), .ext_irq5_pin_low(p5), .ext_irq4_pin_high(p4),
        .ext_irq3_pin_low(p3), .ext_irq2_pin_high(p2), .powerfail_pin(pf), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .sfr_hit(sfr_hit), .irq_req(irq_req), .irq_high_prio(irq_high_prio),
        .irq_source(irq_source), .uart1_baud_doubler(uart1_baud_doubler));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    // Expected {high, source}: high level first, then pf, 2, 3, 4, 5
    function automatic logic [3:0] exp_irq(input logic [7:0] f, e, p, c);
        logic [4:0] pend, hi;
        pend = {f[7:4] & e[3:0], c[4] & c[5]};
        hi = {pend[4:1] & p[3:0], pend[0]};
        for (int i = 0; i < 5; i++) if (hi[i]) return {1'b1, 3'(i + 1)};
        for (int i = 0; i < 5; i++) if (pend[i]) return {1'b0, 3'(i + 1)};
        return 4'h0;
    endfunction
    task chk(input logic [7:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task finish_test;
        if (miscompares == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, d);
        @(posedge core_clk); sfr_addr <= a; sfr_wdata <= d; sfr_wr <= 1'b1;
        @(posedge core_clk); sfr_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, exp, input logic hit);
        @(posedge core_clk); sfr_addr <= a; sfr_rd <= 1'b1;
        @(posedge core_clk); sfr_rd <= 1'b0;
        @(negedge core_clk); chk(sfr_rdata, exp); chk({7'h0, sfr_hit}, {7'h0, hit});
    endtask
    // Hang guard, well above the expected run length
    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 20000) begin miscompares++; finish_test; end
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        rd(8'h91, 8'h08, 1'b1); rd(8'hd8, 8'h40, 1'b1);
        rd(8'he8, 8'he0, 1'b1); rd(8'hf8, 8'he0, 1'b1);
        rd(8'h92, 8'h00, 1'b0);
        wr(8'he8, 8'hff); wr(8'hd8, 8'h20);
        // Each pin in turn: request, sticky flag, software clear
        for (int i = 0; i < 5; i++) begin
            @(posedge core_clk) fire <= 5'h1 << i;
            repeat (4) @(posedge core_clk);
            fire <= 5'h0;
            repeat (6) @(posedge core_clk);
            @(negedge core_clk);
            chk({4'h0, irq_req, irq_source}, 8'(9 + i));
            repeat (20) @(posedge core_clk);
            rd(i ? 8'h91 : 8'hd8, i ? {4'h1 << (i - 1), 4'h8} : 8'h70, 1'b1);
            chk({7'h0, irq_req}, 8'h1);
            wr(i ? 8'h91 : 8'hd8, i ? 8'h00 : 8'h20);
        end
        // Random register settings, first one a hand-picked corner
        for (int k = 0; k < 80; k++) begin
            seed = xs(seed);
            {e, p, f, c} = k ? seed : 32'hff00f030;
            e[4] = 1'b0;
            p[4] = 1'b0;
            wr(8'he8, e); wr(8'hf8, p); wr(8'h91, f); wr(8'hd8, c);
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            x = exp_irq(f, e, p, c);
            chk({4'h0, irq_req, irq_source}, {4'h0, x[2:0] != 3'h0, x[2:0]});
            if (irq_req === 1'b1) chk({7'h0, irq_high_prio}, {7'h0, x[3]});
            chk({7'h0, uart1_baud_doubler}, {7'h0, c[7]});
            rd(8'h91, {f[7:4], 4'h8}, 1'b1);
            rd(8'hd8, {c[7], 1'b1, c[5:4], 4'h0}, 1'b1);
            rd(8'he8, {4'he, e[3:0]}, 1'b1); rd(8'hf8, {4'he, p[3:0]}, 1'b1);
        end
        finish_test;
    end
endmodule // testbench
bind eiu_top eiu_props u_props (.core_clk(core_clk), .rst(rst), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_hit(sfr_hit), .irq_req(irq_req), .irq_high_prio(irq_high_prio),
    .ext_irq5_pin_low(ext_irq5_pin_low), .ext_irq4_pin_high(ext_irq4_pin_high),
    .ext_irq3_pin_low(ext_irq3_pin_low), .ext_irq2_pin_high(ext_irq2_pin_high),
    .powerfail_pin(powerfail_pin), .uart1_baud_doubler(uart1_baud_doubler),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .irq_source(irq_source));
